// ---- core/ckswr_top.v ----
`timescale 1ns/1ns
`include "ckswr_defs.vh"
module ckswr_top #(
  parameter [2:0] RESET_SOURCE = 3'h0
) (
  input  wire        clock,
  input  wire        resetn,
  input  wire [1:0]  addr,
  input  wire [15:0] wdata,
  input  wire [1:0]  byte_en,
  input  wire        wr,
  input  wire        rd,
  output reg  [15:0] rdata,
  input  wire        switch_config_fuse,
  input  wire        new_clk_tick,
  input  wire        crystal_startup_done,
  input  wire        pll_locked,
  input  wire        primary_tick,
  input  wire        sleep_mode,
  input  wire        low_power_rc_needed,
  input  wire        clock_fail_event,
  output reg  [7:0]  osc_enable,
  output reg  [2:0]  sysclk_sel,
  output reg         switch_busy,
  output reg         refclk_out_pin,
  output reg         refclk_out_oe
);
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_CHECK = 3'h1;
  localparam [2:0] ST_WAIT = 3'h2;
  localparam [2:0] ST_SETTLE = 3'h3;
  localparam [2:0] ST_SWAP = 3'h4;

  reg  [2:0]  current_source_sel;
  reg  [2:0]  next_source_sel;
  reg         switch_request;
  reg         secondary_osc_enable;
  reg         lock_status;
  reg         clock_fail_flag;
  reg  [1:0]  hi_key;
  reg  [1:0]  lo_key;
  reg  [2:0]  state;
  reg  [3:0]  settle_cnt;
  reg         refclk_out_enable;
  reg         refclk_sleep_run;
  reg         refclk_source_sel;
  reg  [3:0]  refclk_divisor;
  reg  [14:0] div_cnt;
  reg         base_toggle;
  reg  [15:0] next_rdata;
  wire        wr_hi;
  wire        wr_lo;
  wire        base_tick;
  wire        ref_run;
  wire [15:0] osc_control_reg;

  function is_pll;
    input [2:0] src;
    begin
      is_pll = (src == `CKSWR_SRC_PRIPLL) || (src == `CKSWR_SRC_FAST_RC_WITH_PLL);
    end
  endfunction

  function is_crystal;
    input [2:0] src;
    begin
      is_crystal = (src == `CKSWR_SRC_PRI) || (src == `CKSWR_SRC_PRIPLL) ||
                   (src == `CKSWR_SRC_SEC);
    end
  endfunction

  assign wr_hi = wr && (addr == `CKSWR_ADDR_OSC) && byte_en[1];
  assign wr_lo = wr && (addr == `CKSWR_ADDR_OSC) && byte_en[0];
  assign osc_control_reg = {1'b0, current_source_sel, 1'b0, next_source_sel,
                            2'b00, lock_status, 1'b0, clock_fail_flag, 1'b0,
                            secondary_osc_enable, switch_request};

  ////////////////////////////////////////////////////////////////////////////
  // Unlock keys and control register writes
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      hi_key <= 2'h0;
      lo_key <= 2'h0;
      next_source_sel <= 3'h0;
      secondary_osc_enable <= 1'b0;
    end else begin
      if (wr_hi) begin
        if (hi_key == 2'h2) begin
          if (!switch_config_fuse && !switch_request)
            next_source_sel <= wdata[10:8];
          hi_key <= 2'h0;
        end else if (wdata[15:8] == `CKSWR_KEY_HI_A)
          hi_key <= 2'h1;
        else if (hi_key == 2'h1 && wdata[15:8] == `CKSWR_KEY_HI_B)
          hi_key <= 2'h2;
        else
          hi_key <= 2'h0;
      end
      if (wr_lo) begin
        if (lo_key == 2'h2) begin
          secondary_osc_enable <= wdata[`CKSWR_BIT_SECEN];
          lo_key <= 2'h0;
        end else if (wdata[7:0] == `CKSWR_KEY_LO_A)
          lo_key <= 2'h1;
        else if (lo_key == 2'h1 && wdata[7:0] == `CKSWR_KEY_LO_B)
          lo_key <= 2'h2;
        else
          lo_key <= 2'h0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Switch sequencer; CPU clock stays on old source until ST_SWAP
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state <= ST_IDLE;
      switch_request <= 1'b0;
      current_source_sel <= 3'h0;
      sysclk_sel <= 3'h0;
      osc_enable <= 8'h01;
      settle_cnt <= 4'h0;
      lock_status <= 1'b0;
      clock_fail_flag <= 1'b0;
      switch_busy <= 1'b0;
    end else begin
      if (state == ST_IDLE && current_source_sel == 3'h0 && osc_enable == 8'h01
          && sysclk_sel != RESET_SOURCE && !switch_busy) begin
        current_source_sel <= RESET_SOURCE;
        sysclk_sel <= RESET_SOURCE;
        osc_enable <= 8'h01 << RESET_SOURCE;
        switch_busy <= 1'b1;
      end
      if (is_pll(current_source_sel) || state != ST_IDLE)
        lock_status <= lock_status | (is_pll(next_source_sel) && pll_locked);
      else
        lock_status <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (wr_lo && lo_key == 2'h2 && wdata[`CKSWR_BIT_REQ] && !switch_config_fuse) begin
            switch_request <= 1'b1;
            state <= ST_CHECK;
          end
        end
        ST_CHECK: begin
          if (current_source_sel == next_source_sel) begin
            switch_request <= 1'b0;
            state <= ST_IDLE;
          end else begin
            lock_status <= 1'b0;
            clock_fail_flag <= 1'b0;
            osc_enable[next_source_sel] <= 1'b1;
            state <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if ((!is_crystal(next_source_sel) || crystal_startup_done) &&
              (!is_pll(next_source_sel) || lock_status)) begin
            settle_cnt <= 4'h0;
            state <= ST_SETTLE;
          end
        end
        ST_SETTLE: begin
          if (new_clk_tick) begin
            if (settle_cnt == `CKSWR_SETTLE_CYCLES - 4'h1)
              state <= ST_SWAP;
            else
              settle_cnt <= settle_cnt + 4'h1;
          end
        end
        ST_SWAP: begin
          sysclk_sel <= next_source_sel;
          current_source_sel <= next_source_sel;
          switch_request <= 1'b0;
          osc_enable[current_source_sel] <=
            (current_source_sel == `CKSWR_SRC_LOW_POWER_RC && low_power_rc_needed) ||
            (current_source_sel == `CKSWR_SRC_SEC && secondary_osc_enable);
          state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
      // A failure seen in the same cycle as a switch start must not be lost
      if (clock_fail_event && !switch_config_fuse)
        clock_fail_flag <= 1'b1;
      if (switch_config_fuse)
        switch_request <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reference clock control and divider
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      refclk_out_enable <= 1'b0;
      refclk_sleep_run <= 1'b0;
      refclk_source_sel <= 1'b0;
      refclk_divisor <= 4'h0;
    end else if (wr && addr == `CKSWR_ADDR_REFCLK && byte_en[1]) begin
      refclk_out_enable <= wdata[`CKSWR_BIT_REFCLK_OUT_ENABLE];
      refclk_sleep_run <= wdata[`CKSWR_BIT_ROSLP];
      refclk_source_sel <= wdata[`CKSWR_BIT_REFCLK_SOURCE_SEL];
      refclk_divisor <= wdata[11:8];
    end
  end

  // Base clock is modelled as a tick stream: primary ticks or every system cycle
  assign base_tick = refclk_source_sel ? primary_tick : 1'b1;
  // Without primary selected the primary powers down in Sleep
  assign ref_run = refclk_out_enable &&
                   (!sleep_mode || (refclk_sleep_run && refclk_source_sel &&
                    current_source_sel[2:1] == 2'b01));

  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      div_cnt <= 15'h0000;
      base_toggle <= 1'b0;
      refclk_out_pin <= 1'b0;
      refclk_out_oe <= 1'b0;
    end else begin
      refclk_out_oe <= refclk_out_enable;
      if (base_tick) begin
        base_toggle <= ~base_toggle;
        div_cnt <= div_cnt + 15'h0001;
      end
      if (!ref_run)
        refclk_out_pin <= 1'b0;
      else if (refclk_divisor == 4'h0)
        refclk_out_pin <= base_toggle;
      else
        refclk_out_pin <= div_cnt[refclk_divisor - 4'h1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port
  always @* begin
    case (addr)
      `CKSWR_ADDR_OSC:    next_rdata = osc_control_reg;
      `CKSWR_ADDR_REFCLK: next_rdata = {refclk_out_enable, 1'b0, refclk_sleep_run,
                                        refclk_source_sel, refclk_divisor, 8'h00};
      `CKSWR_ADDR_READY:  next_rdata = {13'h0000, state};
      default:            next_rdata = 16'h0000;
    endcase
  end

  always @(posedge clock or negedge resetn) begin
    if (!resetn)
      rdata <= 16'h0000;
    else if (rd)
      rdata <= next_rdata;
    else
      rdata <= 16'h0000;
  end
endmodule

// ---- include/ckswr_defs.vh ----
`ifndef CKSWR_DEFS_VH
`define CKSWR_DEFS_VH
`define CKSWR_ADDR_OSC      2'h0
`define CKSWR_ADDR_REFCLK   2'h1
`define CKSWR_ADDR_READY    2'h2
`define CKSWR_KEY_HI_A      8'h78
`define CKSWR_KEY_HI_B      8'h9A
`define CKSWR_KEY_LO_A      8'h46
`define CKSWR_KEY_LO_B      8'h57
`define CKSWR_SRC_FRC       3'h0
`define CKSWR_SRC_FAST_RC_WITH_PLL    3'h1
`define CKSWR_SRC_PRI       3'h2
`define CKSWR_SRC_PRIPLL    3'h3
`define CKSWR_SRC_SEC       3'h4
`define CKSWR_SRC_LOW_POWER_RC      3'h5
`define CKSWR_SRC_LPFRCDIV  3'h6
`define CKSWR_SRC_FRCDIV    3'h7
`define CKSWR_BIT_REQ       0
`define CKSWR_BIT_SECEN     1
`define CKSWR_BIT_CF        3
`define CKSWR_BIT_LOCK      5
`define CKSWR_BIT_REFCLK_OUT_ENABLE      15
`define CKSWR_BIT_ROSLP     13
`define CKSWR_BIT_REFCLK_SOURCE_SEL     12
`define CKSWR_SETTLE_CYCLES 4'hA
`endif

// ---- testbench/ckswr_checks_asserts.sv ----
`timescale 1ns/1ns
module ckswr_checks (
  input wire        clock,
  input wire        resetn,
  input wire [1:0]  addr,
  input wire        wr,
  input wire        rd,
  input wire [15:0] rdata,
  input wire        switch_config_fuse,
  input wire        new_clk_tick,
  input wire [7:0]  osc_enable,
  input wire [2:0]  sysclk_sel,
  input wire        refclk_out_pin,
  input wire        refclk_out_oe
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////////////////////////
  a_rdata_idle: assert property (!$past(rd) |-> rdata == 16'h0000)
    else $error("read data not zero outside read answer");
  a_rsvd_index: assert property ($past(rd) && $past(addr) == 2'h3 |-> rdata == 16'h0000)
    else $error("unused index read not zero");
  a_refclk_rsvd: assert property ($past(rd) && $past(addr) == 2'h1 |-> rdata[14] == 1'b0 && rdata[7:0] == 8'h00)
    else $error("unimplemented refclk bits read nonzero");
  a_fuse_req_zero: assert property ($past(rd) && $past(addr) == 2'h0 && $past(switch_config_fuse) |-> !rdata[0])
    else $error("switch request set while switching disabled");
  a_fuse_hold_sel: assert property (switch_config_fuse |=> $stable(sysclk_sel))
    else $error("system clock changed while switching disabled");
  // Changeover may only follow a new-clock tick, never a bare timer
  a_swap_after_tick: assert property ($changed(sysclk_sel) |-> $past(new_clk_tick) || $past(new_clk_tick, 2) || $past(new_clk_tick, 3))
    else $error("changeover without recent new clock tick");
  a_sel_osc_on: assert property (osc_enable[sysclk_sel])
    else $error("selected source not running");
  a_pin_low_off: assert property (!refclk_out_oe |-> !refclk_out_pin)
    else $error("reference pin high while disabled");
  a_oe_after_write: assert property ($rose(refclk_out_oe) |-> $past(wr, 2) && $past(addr, 2) == 2'h1)
    else $error("reference enable rose without register write");
endmodule

// ---- testbench/clock_switch_and_refclk_out_bench.sv ----
`timescale 1ns/1ns
module clock_switch_and_refclk_out_bench;
  logic        clock = 1'b0, resetn = 1'b0, wr = 1'b0, rd = 1'b0, fuse = 1'b0;
  logic        tick = 1'b0, ptick = 1'b0, slp = 1'b0, cfe = 1'b0;
  logic [1:0]  addr = 2'h0, be = 2'h0;
  logic [15:0] wdata = 16'h0000;
  logic [2:0]  cur = 3'h0;
  logic [2:0]  seq [8] = '{3'h3, 3'h0, 3'h1, 3'h4, 3'h5, 3'h6, 3'h7, 3'h2};
  wire  [15:0] rdata;
  wire  [7:0]  oen;
  wire  [2:0]  sel;
  wire         pin, oe, busy;
  int          err_total = 0, compares = 0, cycles = 0;
  ckswr_top uut (
    .clock(clock), .resetn(resetn), .addr(addr), .wdata(wdata), .byte_en(be), .wr(wr),
    .rd(rd), .rdata(rdata), .switch_config_fuse(fuse), .new_clk_tick(tick),
    .crystal_startup_done(1'b1), .pll_locked(1'b1), .primary_tick(ptick), .sleep_mode(slp),
    .low_power_rc_needed(1'b0), .clock_fail_event(cfe), .osc_enable(oen), .sysclk_sel(sel),
    .switch_busy(busy), .refclk_out_pin(pin), .refclk_out_oe(oe)
  );
  always #50 clock = ~clock;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      end_of_test;
    end
  end
  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Each access starts on a rising edge by non-blocking assignment
  task automatic wrr(logic [1:0] a, logic [1:0] b, logic [15:0] d);
    addr <= a;
    be <= b;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task automatic rdc(string nm, logic [1:0] a, logic [15:0] m, logic [15:0] exp);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 chk(nm, rdata & m, exp);
    @(posedge clock);
  endtask
  task automatic tk(int n);
    repeat (n) begin
      tick <= 1'b1;
      @(posedge clock);
      tick <= 1'b0;
      @(posedge clock);
    end
  endtask
  task automatic sw(logic [2:0] code, logic [2:0] exp);
    wrr(2'h0, 2'h2, 16'h7800);
    wrr(2'h0, 2'h2, 16'h9A00);
    wrr(2'h0, 2'h2, {5'h00, code, 8'h00});
    wrr(2'h0, 2'h1, 16'h0046);
    wrr(2'h0, 2'h1, 16'h0057);
    wrr(2'h0, 2'h1, 16'h0001);
    repeat (4) @(posedge clock);
    tk(9);
    repeat (3) @(posedge clock);
    chk("sysclk early", 16'(sel), 16'(cur));
    tk(1);
    repeat (3) @(posedge clock);
    chk("sysclk", 16'(sel), 16'(exp));
    if (exp != cur) chk("old osc", 16'(oen[cur]), 16'h0000);
    rdc("osc reg", 2'h0, 16'h7009, {1'b0, exp, 12'h000});
    cur = exp;
  endtask
  // Ticks come every other cycle so the pin is sampled once per tick
  task automatic cnt(string nm, int exp);
    int n;
    logic p;
    n = 0;
    p = pin;
    repeat (64) begin
      ptick <= 1'b1;
      @(posedge clock);
      ptick <= 1'b0;
      @(posedge clock);
      if (pin && !p) n++;
      p = pin;
    end
    chk(nm, 16'(exp > 0 ? (n >= exp - 1 && n <= exp + 1) : n == 0), 16'h0001);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clock);
    resetn <= 1'b1;
    repeat (2) @(posedge clock);
    rdc("refclk reset", 2'h1, 16'hFFFF, 16'h0000);
    rdc("state idle", 2'h2, 16'hFFFF, 16'h0000);
    rdc("unused index", 2'h3, 16'hFFFF, 16'h0000);
    chk("busy", 16'(busy), 16'h0000);
    wrr(2'h0, 2'h2, 16'h0500);
    wrr(2'h0, 2'h2, 16'h9A00);
    wrr(2'h0, 2'h2, 16'h7800);
    wrr(2'h0, 2'h2, 16'h0600);
    wrr(2'h0, 2'h1, 16'h0001);
    rdc("locked osc", 2'h0, 16'h0701, 16'h0000);
    cfe <= 1'b1;
    @(posedge clock);
    cfe <= 1'b0;
    rdc("clock fail", 2'h0, 16'h0008, 16'h0008);
    foreach (seq[i]) sw(seq[i], seq[i]);
    sw(3'h2, 3'h2);
    wrr(2'h1, 2'h3, 16'hFFFF);
    rdc("refclk bits", 2'h1, 16'hFFFF, 16'hBF00);
    repeat (2) @(posedge clock);
    chk("refclk oe", 16'(oe), 16'h0001);
    for (int d = 0; d < 4; d++) begin
      wrr(2'h1, 2'h3, {4'h9, 4'(d), 8'h00});
      cnt("divider", 64 >> (d == 0 ? 1 : d));
    end
    wrr(2'h1, 2'h3, 16'hB300);
    slp <= 1'b1;
    cnt("sleep run", 8);
    wrr(2'h1, 2'h3, 16'h9300);
    cnt("sleep stop", 0);
    wrr(2'h1, 2'h3, 16'h1300);
    slp <= 1'b0;
    cnt("disabled", 0);
    fuse <= 1'b1;
    sw(3'h0, 3'h2);
    end_of_test;
  end
endmodule
bind ckswr_top ckswr_checks chk_i (.*);
